// *** core/pnp_pkg.sv ***
// Constants for the per-port auto-negotiation page register bank
// Behaviour
// - Partner base page reads back read-only with its documented field layout.
// - Partner pause field decodes: 11 both, 10 asym to partner, 01 sym, 00 none.
// - Each partner technology ability bit reads 1 when the partner advertises it.
// - Partner remote fault bit reads 1 when its base page signals a fault.
// - Expansion bit 4 latches high on a parallel detection fault.
// - Expansion bit 1 latches high when a new page is received.
// - Expansion bit 2 reads 1 after reset: local next page capable.
// - Expansion bit 3 partner next page able, bit 0 partner AN able, 15:5 zero.
// - Local next page bit 15 more-pages flag resets 0; message field resets 0x001.
// - Local next page bit 13 selects message or unformatted page, resets 1.
// - Local next page bit 12 acknowledge-2 is writable and resets 0.
// - Local next page bit 11 toggle is device-kept, read-only, resets 0.
// - Partner next page bit 14 holds the acknowledge bit of the last received word.
// - Partner next page bits 13, 12 and 10:0 hold the received fields.
// - Partner next page bit 11 keeps the partner's toggle polarity as received.
package pnp_pkg;

  localparam int NUM_PORTS = 5;
  localparam int PG_W = 16;
  localparam int IRQ_W = 2 * NUM_PORTS;

  // Word index is {port, register}; byte address is four times the index
  localparam int ADR_MSB = 8;
  localparam logic [2:0] PORT_FIRST = 3'h1;
  localparam logic [3:0] IDX_BASE = 4'h5;
  localparam logic [3:0] IDX_EXP = 4'h6;
  localparam logic [3:0] IDX_NPTX = 4'h7;
  localparam logic [3:0] IDX_NPRX = 4'h8;
  // Global block at port field 0
  localparam logic [2:0] PORT_GLOBAL = 3'h0;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h0;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h1;

  // Page word fields
  localparam int NP_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int MP_BIT = 13;
  localparam int ACK2_BIT = 12;
  localparam int TOG_BIT = 11;
  localparam int MSG_MSB = 10;
  localparam int PAUSE_HI = 11;
  localparam int PAUSE_LO = 10;

  // Pause encodings
  localparam logic [1:0] PAUSE_BOTH = 2'h3;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PAUSE_SYM = 2'h1;

  // Reset values
  localparam logic [10:0] MSG_RST = 11'h001;
  localparam logic MP_RST = 1'b1;
  localparam logic [10:0] EXP_RSVD = 11'h000;

  // Interrupt layout: page received in low half, fault in high half
  localparam int IRQ_PR_LSB = 0;
  localparam int IRQ_PDF_LSB = NUM_PORTS;

endpackage : pnp_pkg

// *** core/pnp_regs.sv ***
// Auto-negotiation page registers for five PHY ports with Wishbone access
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module pnp_regs
  import pnp_pkg::*;
(
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [ADR_MSB:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_o, // Level interrupt
  input wire logic [NUM_PORTS*PG_W-1:0] base_page_i, // Received base pages
  input wire logic [NUM_PORTS-1:0] base_page_stb_i, // Base page valid
  input wire logic [NUM_PORTS*PG_W-1:0] next_page_i, // Received next pages
  input wire logic [NUM_PORTS-1:0] next_page_stb_i, // Next page valid
  input wire logic [NUM_PORTS-1:0] pd_fault_i, // Parallel detect fault
  input wire logic [NUM_PORTS-1:0] lp_an_able_i, // Partner does AN
  input wire logic [NUM_PORTS-1:0] tx_page_sent_i, // Local page sent
  output logic [NUM_PORTS*PG_W-1:0] np_tx_word_o, // Next page to send
  output logic [NUM_PORTS-1:0] lp_pause_sym_o, // Partner symmetric
  output logic [NUM_PORTS-1:0] lp_pause_asym_o // Partner asymmetric
);

  // Decoded bus request, taken once per cycle before ack rises
  logic req;
  logic wr;
  logic rd;
  logic [2:0] adr_port;
  logic [3:0] adr_idx;
  logic [31:0] rd_nxt;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign adr_port = wb_adr_i[ADR_MSB:6];
  assign adr_idx = wb_adr_i[5:2];

  // Per-port views gathered for the read mux
  logic [PG_W-1:0] base_v [NUM_PORTS];
  logic [PG_W-1:0] exp_v [NUM_PORTS];
  logic [PG_W-1:0] nptx_v [NUM_PORTS];
  logic [PG_W-1:0] nprx_v [NUM_PORTS];
  logic [NUM_PORTS-1:0] ev_pr;
  logic [NUM_PORTS-1:0] ev_pdf;

  // Merge write data into a 16-bit register honouring byte lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [1:0] sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : lane_merge

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic hit;
      logic rd_exp;
      logic [PG_W-1:0] base_r;
      logic [PG_W-1:0] nprx_r;
      logic [PG_W-1:0] nprx_nxt;
      logic [PG_W-1:0] nptx_nxt;
      logic np_r;
      logic mp_r;
      logic ack2_r;
      logic [MSG_MSB:0] msg_r;
      logic tog_r;
      logic pdf_r;
      logic prx_r;
      logic npa_r;
      logic got_page;

      // Each copy answers only to its own port number
      assign hit = (adr_port == PORT_FIRST + 3'(g));
      assign rd_exp = rd & hit & (adr_idx == IDX_EXP);
      assign got_page = base_page_stb_i[g] | next_page_stb_i[g];

      // Partner base page, captured whole and never written by software
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          base_r <= '0;
        end else if (base_page_stb_i[g]) begin
          base_r <= base_page_i[g*PG_W +: PG_W];
        end
      end

      // Partner pause capability decoded for the flow control logic
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lp_pause_sym_o[g] <= 1'b0;
          lp_pause_asym_o[g] <= 1'b0;
        end else begin
          case (base_r[PAUSE_HI:PAUSE_LO])
            PAUSE_BOTH: begin
              lp_pause_sym_o[g] <= 1'b1;
              lp_pause_asym_o[g] <= 1'b1;
            end
            PAUSE_ASYM: begin
              lp_pause_sym_o[g] <= 1'b0;
              lp_pause_asym_o[g] <= 1'b1;
            end
            PAUSE_SYM: begin
              lp_pause_sym_o[g] <= 1'b1;
              lp_pause_asym_o[g] <= 1'b0;
            end
            default: begin
              lp_pause_sym_o[g] <= 1'b0;
              lp_pause_asym_o[g] <= 1'b0;
            end
          endcase
        end
      end

      // Partner next page; a fresh page overrides a software write
      always_comb begin
        nprx_nxt = nprx_r;
        if (wr && hit && adr_idx == IDX_NPRX && wb_sel_i[1]) begin
          nprx_nxt[NP_BIT] = wb_dat_i[NP_BIT];
        end
        if (next_page_stb_i[g]) begin
          nprx_nxt = next_page_i[g*PG_W +: PG_W];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          nprx_r <= '0;
        end else begin
          nprx_r <= nprx_nxt;
        end
      end

      // Local next page fields written by software
      assign nptx_nxt = lane_merge(nptx_v[g], wb_dat_i[15:0], wb_sel_i[1:0]);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          np_r <= 1'b0;
          mp_r <= MP_RST;
          ack2_r <= 1'b0;
          msg_r <= MSG_RST;
        end else if (wr && hit && adr_idx == IDX_NPTX) begin
          np_r <= nptx_nxt[NP_BIT];
          mp_r <= nptx_nxt[MP_BIT];
          ack2_r <= nptx_nxt[ACK2_BIT];
          msg_r <= nptx_nxt[MSG_MSB:0];
        end
      end

      // Toggle flips per sent page; software cannot write it
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tog_r <= 1'b0;
        end else if (tx_page_sent_i[g]) begin
          tog_r <= ~tog_r;
        end
      end

      // Word handed to the negotiation engine carries the next toggle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          np_tx_word_o[g*PG_W +: PG_W] <= '0;
        end else begin
          np_tx_word_o[g*PG_W +: PG_W] <= {np_r, 1'b0, mp_r, ack2_r,
                                           ~tog_r, msg_r};
        end
      end

      // Latched-high flags; a new event beats the read clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pdf_r <= 1'b0;
        end else begin
          pdf_r <= pd_fault_i[g] | (pdf_r & ~rd_exp);
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prx_r <= 1'b0;
        end else begin
          prx_r <= got_page | (prx_r & ~rd_exp);
        end
      end

      // Local next page ability is fixed on
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          npa_r <= 1'b1;
        end else begin
          npa_r <= 1'b1;
        end
      end

      // Register views
      assign base_v[g] = base_r;
      assign exp_v[g] = {EXP_RSVD, pdf_r, base_r[NP_BIT], npa_r, prx_r,
                         lp_an_able_i[g]};
      assign nptx_v[g] = {np_r, 1'b0, mp_r, ack2_r, tog_r, msg_r};
      assign nprx_v[g] = nprx_r;
      assign ev_pr[g] = got_page;
      assign ev_pdf[g] = pd_fault_i[g];
    end
  endgenerate

  // Interrupt status and mask, same layout
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_wdat;
  logic [IRQ_W-1:0] irq_clr;
  logic [15:0] irq_wdat_full;
  logic [15:0] irq_mask_full;
  logic glb_hit;

  assign glb_hit = (adr_port == PORT_GLOBAL);

  // Lanes merged at full register width, then cut to the event bits;
  // bits above the event count are not stored and read back zero
  assign irq_wdat_full = lane_merge(16'h0000, wb_dat_i[15:0],
                                    wb_sel_i[1:0]);
  assign irq_wdat = irq_wdat_full[IRQ_W-1:0];
  assign irq_mask_full = lane_merge(16'(irq_mask_r), wb_dat_i[15:0],
                                    wb_sel_i[1:0]);

  // Write-one-to-clear strobe, only in the cycle the write is taken
  assign irq_clr = (wr && glb_hit && adr_idx == IDX_IRQ_STAT) ?
                   irq_wdat : '0;

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | {ev_pdf, ev_pr};
    end
  end

  // Mask written through byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wr && glb_hit && adr_idx == IDX_IRQ_MASK) begin
      irq_mask_r <= irq_mask_full[IRQ_W-1:0];
    end
  end

  // Registered level keeps the output glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read mux; unmapped addresses read zero
  // Sampled on the taking edge, so a read-clear sees the value before it
  always_comb begin
    rd_nxt = '0;
    if (glb_hit) begin
      case (adr_idx)
        IDX_IRQ_STAT: rd_nxt = 32'(irq_stat_r);
        IDX_IRQ_MASK: rd_nxt = 32'(irq_mask_r);
        default: rd_nxt = '0;
      endcase
    end else if (adr_port >= PORT_FIRST &&
                 adr_port < PORT_FIRST + 3'(NUM_PORTS)) begin
      case (adr_idx)
        IDX_BASE: rd_nxt = 32'(base_v[adr_port - PORT_FIRST]);
        IDX_EXP: rd_nxt = 32'(exp_v[adr_port - PORT_FIRST]);
        IDX_NPTX: rd_nxt = 32'(nptx_v[adr_port - PORT_FIRST]);
        IDX_NPRX: rd_nxt = 32'(nprx_v[adr_port - PORT_FIRST]);
        default: rd_nxt = '0;
      endcase
    end
  end

  // Single-wait acknowledge; dropped the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= rd_nxt;
    end
  end

endmodule : pnp_regs

// *** bench/pnp_regs_monitor.sv ***
// Bus timing, reset and page decode checks for the register bank
`timescale 1ns/1ps
module pnp_regs_monitor
  import pnp_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [ADR_MSB:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [NUM_PORTS*PG_W-1:0] base_page_i, // Base pages
  input wire logic [NUM_PORTS-1:0] base_page_stb_i, // Base strobes
  input wire logic [NUM_PORTS-1:0] tx_page_sent_i, // Sent pulses
  input wire logic [NUM_PORTS*PG_W-1:0] np_tx_word_o, // Outgoing pages
  input wire logic [NUM_PORTS-1:0] lp_pause_sym_o, // Sym pause
  input wire logic [NUM_PORTS-1:0] lp_pause_asym_o // Asym pause
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Ack one cycle after a taken request, and for one cycle only
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper data not zero");
  // Reset must hold the bus quiet, so it is not disabled by itself
  property p_rst; disable iff (1'b0) rst_i |=> !wb_ack_o; endproperty
  a_rst: assert property (p_rst) else $error("ack in reset");
  property p_pau;
    base_page_stb_i[0] ##1 !base_page_stb_i[0] |=>
      {lp_pause_asym_o[0], lp_pause_sym_o[0]} == $past(base_page_i[11:10], 2);
  endproperty
  a_pau: assert property (p_pau) else $error("pause decode");
  property p_np; $fell(rst_i) |=> np_tx_word_o[15:0] == 16'h2801; endproperty
  a_np: assert property (p_np) else $error("page reset");
  // Toggle flips per sent word; the outgoing copy lags two cycles
  property p_tog;
    !tx_page_sent_i[0] ##1 tx_page_sent_i[0] ##1 !tx_page_sent_i[0] |=>
      np_tx_word_o[11] != $past(np_tx_word_o[11], 2);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle stuck");
  property p_exp;
    wb_ack_o && !wb_we_i && wb_adr_i == 9'h058 |->
      wb_dat_o[15:5] == 11'h000 && wb_dat_o[2];
  endproperty
  a_exp: assert property (p_exp) else $error("expansion fixed bits");
  cover property (wb_ack_o && !wb_we_i);
  cover property (tx_page_sent_i[0]);
  cover property (base_page_stb_i[4]);
endmodule : pnp_regs_monitor

bind pnp_regs pnp_regs_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .base_page_i, .base_page_stb_i,
  .tx_page_sent_i, .np_tx_word_o, .lp_pause_sym_o, .lp_pause_asym_o);

// *** bench/pnp_lp_model.sv ***
// Remote link partner: delivers pages, levels and sent pulses
`timescale 1ns/1ps
module pnp_lp_model
  import pnp_pkg::*;
(
  input wire logic clk_i, // Clock
  output logic [NUM_PORTS*PG_W-1:0] base_o = '0, // Base pages
  output logic [NUM_PORTS-1:0] base_stb_o = '0, // Base strobes
  output logic [NUM_PORTS*PG_W-1:0] next_o = '0, // Next pages
  output logic [NUM_PORTS-1:0] next_stb_o = '0, // Next strobes
  output logic [NUM_PORTS-1:0] fault_o = '0, // Detect fault
  output logic [NUM_PORTS-1:0] an_o = '0, // Partner AN able
  output logic [NUM_PORTS-1:0] sent_o = '0 // Local page sent
);
  // One-cycle strobe; word lines flip once released, so stale data shows
  task page(input logic nxt, input int p, input logic [15:0] w);
    @(posedge clk_i);
    if (nxt) begin
      next_o[p*PG_W+:PG_W] <= w;
      next_stb_o[p] <= 1'b1;
    end else begin
      base_o[p*PG_W+:PG_W] <= w;
      base_stb_o[p] <= 1'b1;
    end
    @(posedge clk_i);
    next_stb_o <= '0;
    base_stb_o <= '0;
    if (nxt) next_o[p*PG_W+:PG_W] <= ~w;
    else base_o[p*PG_W+:PG_W] <= ~w;
  endtask : page
  task sent(input int p);
    @(posedge clk_i);
    sent_o[p] <= 1'b1;
    @(posedge clk_i);
    sent_o <= '0;
  endtask : sent
  task lvl(input logic [4:0] f, input logic [4:0] a);
    @(posedge clk_i);
    fault_o <= f;
    an_o <= a;
  endtask : lvl
endmodule : pnp_lp_model

// *** bench/test_pnp_regs.sv ***
// Register bank bench: bus tasks, partner pages, compared reads
`timescale 1ns/1ps
module test_pnp_regs;
  import pnp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
  logic [ADR_MSB:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic [NUM_PORTS*PG_W-1:0] base_page_i, next_page_i, np_tx_word_o;
  logic [NUM_PORTS-1:0] base_page_stb_i, next_page_stb_i, pd_fault_i;
  logic [NUM_PORTS-1:0] lp_an_able_i, tx_page_sent_i;
  logic [NUM_PORTS-1:0] lp_pause_sym_o, lp_pause_asym_o;
  logic [15:0] w;
  int errors = 0, samples_checked = 0, cyc_n = 0;
  always #20 clk_i = ~clk_i;
  pnp_regs u_pnp_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
    .base_page_i, .base_page_stb_i, .next_page_i, .next_page_stb_i,
    .pd_fault_i, .lp_an_able_i, .tx_page_sent_i, .np_tx_word_o,
    .lp_pause_sym_o, .lp_pause_asym_o);
  pnp_lp_model u_pnp_lp_model (.clk_i, .base_o(base_page_i),
    .base_stb_o(base_page_stb_i), .next_o(next_page_i),
    .next_stb_o(next_page_stb_i), .fault_o(pd_fault_i),
    .an_o(lp_an_able_i), .sent_o(tx_page_sent_i));
  task end_sim;
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the fewer than two hundred cycles needed
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [8:0] ra(input int n, input logic [3:0] i);
    return {n[2:0], i, 2'b00};
  endfunction : ra
  // Classic cycle held until ack is sampled; data taken at that edge
  task bus(input logic we, input logic [8:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task rchk(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h3);
    chk(rd, e);
  endtask : rchk
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    u_pnp_lp_model.lvl(5'h00, 5'h15);
    rchk(ra(1, IDX_EXP), 32'h5);
    rchk(ra(1, IDX_NPTX), 32'h2001);
    bus(1'b1, ra(1, IDX_NPTX), 32'hffff, 4'h3);
    rchk(ra(1, IDX_NPTX), 32'hb7ff);
    u_pnp_lp_model.sent(0);
    rchk(ra(1, IDX_NPTX), 32'hbfff);
    chk({16'h0, np_tx_word_o[15:0]}, 32'hb7ff);
    // Every port gets its own page; pause codes 00 to 11 all appear
    for (int p = 0; p < NUM_PORTS; p++) begin
      w = {~p[2], 1'b1, p[0], 1'b0, p[1:0], 5'h15 ^ p[4:0], 5'h01};
      u_pnp_lp_model.page(1'b0, p, w);
      rchk(ra(p + 1, IDX_BASE), {16'h0, w});
      chk({30'h0, lp_pause_sym_o[p], lp_pause_asym_o[p]},
        {30'h0, w[10], w[11]});
      rchk(ra(p + 1, IDX_EXP), {28'h0, w[15], 2'b11, lp_an_able_i[p]});
      rchk(ra(p + 1, IDX_EXP), {28'h0, w[15], 2'b10, lp_an_able_i[p]});
      bus(1'b1, ra(p + 1, IDX_BASE), 32'h0, 4'h3);
      rchk(ra(p + 1, IDX_BASE), {16'h0, w});
    end
    rchk(ra(0, IDX_IRQ_STAT), 32'h1f);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, ra(0, IDX_IRQ_MASK), 32'h1, 4'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, ra(0, IDX_IRQ_STAT), 32'h1f, 4'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Fault pulse must stay latched until read
    u_pnp_lp_model.lvl(5'h01, 5'h15);
    repeat (2) @(posedge clk_i);
    u_pnp_lp_model.lvl(5'h00, 5'h15);
    rchk(ra(1, IDX_EXP), 32'h1d);
    rchk(ra(1, IDX_EXP), 32'h0d);
    rchk(ra(0, IDX_IRQ_STAT), 32'h20);
    u_pnp_lp_model.page(1'b1, 1, 16'hd5aa);
    rchk(ra(2, IDX_NPRX), 32'hd5aa);
    rchk(ra(2, IDX_EXP), 32'h0e);
    rchk(ra(0, IDX_IRQ_STAT), 32'h22);
    bus(1'b1, ra(2, IDX_NPRX), 32'h0, 4'h2);
    rchk(ra(2, IDX_NPRX), 32'h55aa);
    bus(1'b1, ra(7, 4'hf), 32'hffff, 4'h3);
    rchk(ra(7, 4'hf), 32'h0);
    end_sim;
  end
endmodule : test_pnp_regs
